//--- core/pscl_pkg.sv
// constants for the pin-strap configuration latch
package pscl_pkg;
   // mode and range codes on the two select pins
   localparam logic [1:0] MODE_SOFTWARE = 2'h0;
   localparam logic [1:0] RANGE_2V5 = 2'h1;
   localparam logic [1:0] RANGE_5V = 2'h2;
   localparam logic [1:0] RANGE_10V = 2'h3;
   // interface select level meaning parallel
   localparam logic IFACE_PARALLEL = 1'b0;
   // reset pulse thresholds, in ns, and the clock period
   localparam int CLK_PERIOD_NS = 5;
   localparam int PARTIAL_MIN_NS = 50;
   localparam int FULL_MIN_NS = 1000;
   localparam int SHUTDOWN_MIN_NS = 10000;
   // least times round up
   localparam int PARTIAL_CYC = (PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FULL_CYC = (FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SHUTDOWN_CYC = (SHUTDOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 16;
   // register address map
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CONTROL = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] CONTROL_RESET = 32'h0;
   typedef enum logic [1:0] {PSCL_RUN, PSCL_LOW, PSCL_SHUTDOWN} pscl_rst_e;
endpackage : pscl_pkg

//--- core/pscl_strap_latch.sv
// strap capture, reset pulse classification and register slave
// How it works
// - high reference strap enables internal reference
// - low reference strap disables internal reference
// - capture reference and sequencer straps at full reset
// - classify reset pulse as full or partial
// - long reset low holds shutdown mode
// - captured sequencer strap low keeps sequencer off
// - captured sequencer strap high enables sequencer
// - code 00 selects software mode
// - hardware codes 01/10/11 pick input range
// - mode decided only at full reset
// - hardware range follows pins live
// - interface strap 0 selects parallel interface
// - burst strap captured at full reset hardware mode
module pscl_strap_latch #(
   parameter int PARTIAL_CYCLES = pscl_pkg::PARTIAL_CYC,
   parameter int FULL_CYCLES = pscl_pkg::FULL_CYC,
   parameter int SHUTDOWN_CYCLES = pscl_pkg::SHUTDOWN_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic RESET_PIN_N,
   input wire logic REF_SOURCE_SELECT,
   input wire logic SEQUENCER_ENABLE_STRAP,
   input wire logic MODE_RANGE_SELECT_HI,
   input wire logic MODE_RANGE_SELECT_LO,
   input wire logic INTERFACE_SELECT_STRAP,
   input wire logic BURST_STRAP,
   output logic INT_REF_ENABLE,
   output logic SEQUENCER_ENABLE,
   output logic BURST_ENABLE,
   output logic HARDWARE_MODE,
   output logic [1:0] INPUT_RANGE,
   output logic PARALLEL_IFACE,
   output logic SHUTDOWN,
   output logic FULL_RESET_PULSE,
   output logic PARTIAL_RESET_PULSE,
   input wire logic [3:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [3:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY
);
   ////////////////////////////////////////////////////////////////////////////
   // synchronisers: first stage feeds only the second
   logic [6:0] sync1;
   logic [6:0] sync2;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync1 <= 7'h7f;
         sync2 <= 7'h7f;
      end else begin
         sync1 <= {RESET_PIN_N, REF_SOURCE_SELECT, SEQUENCER_ENABLE_STRAP,
                   MODE_RANGE_SELECT_HI, MODE_RANGE_SELECT_LO,
                   INTERFACE_SELECT_STRAP, BURST_STRAP};
         sync2 <= sync1;
      end
   end
   logic rst_pin_n;
   logic ref_s;
   logic seq_s;
   logic [1:0] sel_s;
   logic par_s;
   logic burst_s;
   assign {rst_pin_n, ref_s, seq_s, sel_s, par_s, burst_s} = sync2;

   ////////////////////////////////////////////////////////////////////////////
   // reset pulse timing
   pscl_pkg::pscl_rst_e state;
   logic [pscl_pkg::CNT_W-1:0] low_cnt;
   logic [pscl_pkg::CNT_W-1:0] partial_thr;
   logic [pscl_pkg::CNT_W-1:0] full_thr;
   logic [pscl_pkg::CNT_W-1:0] shut_thr;
   logic thr_override;
   logic [31:0] control;
   logic full_release;
   logic partial_release;

   // override bit selects the software thresholds; partial field is only 8 bits wide
   assign thr_override = control[0];
   assign partial_thr = thr_override ? {8'h00, control[15:8]}
                                     : pscl_pkg::CNT_W'(PARTIAL_CYCLES);
   assign full_thr = thr_override ? {control[31:16]} : pscl_pkg::CNT_W'(FULL_CYCLES);
   assign shut_thr = pscl_pkg::CNT_W'(SHUTDOWN_CYCLES);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         low_cnt <= '0;
      end else if (rst_pin_n) begin
         low_cnt <= '0;
      end else if (low_cnt != {pscl_pkg::CNT_W{1'b1}}) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // pulses shorter than both the partial and the full threshold are treated as glitches
   assign full_release = rst_pin_n && state != pscl_pkg::PSCL_RUN
                         && low_cnt >= full_thr;
   assign partial_release = rst_pin_n && state == pscl_pkg::PSCL_LOW
                            && low_cnt >= partial_thr && low_cnt < full_thr;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state <= pscl_pkg::PSCL_RUN;
      end else begin
         case (state)
            pscl_pkg::PSCL_RUN: begin
               if (!rst_pin_n) begin
                  state <= pscl_pkg::PSCL_LOW;
               end
            end
            pscl_pkg::PSCL_LOW: begin
               if (rst_pin_n) begin
                  state <= pscl_pkg::PSCL_RUN;
               end else if (low_cnt >= shut_thr) begin
                  state <= pscl_pkg::PSCL_SHUTDOWN;
               end
            end
            pscl_pkg::PSCL_SHUTDOWN: begin
               if (rst_pin_n) begin
                  state <= pscl_pkg::PSCL_RUN;
               end
            end
            default: state <= pscl_pkg::PSCL_RUN;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         FULL_RESET_PULSE <= 1'b0;
         PARTIAL_RESET_PULSE <= 1'b0;
      end else begin
         FULL_RESET_PULSE <= full_release;
         PARTIAL_RESET_PULSE <= partial_release;
      end
   end

   assign SHUTDOWN = (state == pscl_pkg::PSCL_SHUTDOWN);

   ////////////////////////////////////////////////////////////////////////////
   // strap capture at full reset release; defaults until first one
   logic ref_lat;
   logic seq_lat;
   logic hw_lat;
   logic burst_lat;
   logic par_lat;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ref_lat <= 1'b1;
         seq_lat <= 1'b0;
         hw_lat <= 1'b0;
         burst_lat <= 1'b0;
         par_lat <= 1'b0;
      end else if (full_release) begin
         ref_lat <= ref_s;
         seq_lat <= seq_s;
         hw_lat <= (sel_s != pscl_pkg::MODE_SOFTWARE);
         burst_lat <= burst_s;
         par_lat <= par_s;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         INT_REF_ENABLE <= 1'b1;
         SEQUENCER_ENABLE <= 1'b0;
         BURST_ENABLE <= 1'b0;
         HARDWARE_MODE <= 1'b0;
         INPUT_RANGE <= pscl_pkg::MODE_SOFTWARE;
         PARALLEL_IFACE <= 1'b1;
      end else begin
         INT_REF_ENABLE <= ref_lat;
         // strap is grounded in software mode, so this stays low there
         SEQUENCER_ENABLE <= seq_lat;
         BURST_ENABLE <= burst_lat && hw_lat;
         HARDWARE_MODE <= hw_lat;
         // range is live; a 00 seen later in hardware mode keeps 00
         INPUT_RANGE <= hw_lat ? sel_s : pscl_pkg::MODE_SOFTWARE;
         PARALLEL_IFACE <= (par_lat == pscl_pkg::IFACE_PARALLEL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_hold;
   logic w_hold;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_hold && !S_AXI_BVALID;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= pscl_pkg::RESP_OKAY;
         control <= pscl_pkg::CONTROL_RESET;
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_hold <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_hold <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (aw_hold && w_hold) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            if (aw_addr == pscl_pkg::ADDR_CONTROL) begin
               S_AXI_BRESP <= pscl_pkg::RESP_OKAY;
               for (int i = 0; i < 4; i++) begin
                  if (w_strb[i]) begin
                     control[i*8 +: 8] <= w_data[i*8 +: 8];
                  end
               end
            end else begin
               S_AXI_BRESP <= pscl_pkg::RESP_SLVERR;
            end
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   assign S_AXI_ARREADY = !S_AXI_RVALID;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= pscl_pkg::RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= pscl_pkg::RESP_OKAY;
         case (S_AXI_ARADDR)
            pscl_pkg::ADDR_CONFIG: S_AXI_RDATA <= {25'h0, PARALLEL_IFACE, INPUT_RANGE,
                                         HARDWARE_MODE, BURST_ENABLE, SEQUENCER_ENABLE,
                                         INT_REF_ENABLE};
            pscl_pkg::ADDR_STATUS: S_AXI_RDATA <= {14'h0, state == pscl_pkg::PSCL_LOW,
                                         SHUTDOWN, low_cnt};
            pscl_pkg::ADDR_CONTROL: S_AXI_RDATA <= control;
            default: begin
               S_AXI_RDATA <= 32'h0;
               S_AXI_RRESP <= pscl_pkg::RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   capture_ref_a: assert property (@(posedge CLK) disable iff (!RST_N)
      full_release |=> ref_lat == $past(ref_s)) else $error("ref strap not captured");
   hold_ref_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !full_release |=> $stable(ref_lat)) else $error("ref strap changed");
   seq_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
      full_release |=> seq_lat == $past(seq_s))
      else $error("sequencer strap not captured");
   seq_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !full_release |=> $stable(seq_lat))
      else $error("sequencer strap changed");
   ref_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
      FULL_RESET_PULSE |=> INT_REF_ENABLE == $past(ref_s, 2))
      else $error("ref enable wrong");
   seq_out_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !seq_lat |=> !SEQUENCER_ENABLE) else $error("sequencer on");
   seq_on_a: assert property (@(posedge CLK) disable iff (!RST_N)
      seq_lat |=> SEQUENCER_ENABLE) else $error("sequencer off");
   mode_sw_a: assert property (@(posedge CLK) disable iff (!RST_N)
      full_release && sel_s == pscl_pkg::MODE_SOFTWARE |=> ##1 !HARDWARE_MODE)
      else $error("software mode missed");
   range_live_a: assert property (@(posedge CLK) disable iff (!RST_N)
      hw_lat && $stable(hw_lat) |=> INPUT_RANGE == $past(sel_s)) else $error("range stale");
   range_dec_a: assert property (@(posedge CLK) disable iff (!RST_N)
      hw_lat && (sel_s == pscl_pkg::RANGE_2V5 || sel_s == pscl_pkg::RANGE_5V
         || sel_s == pscl_pkg::RANGE_10V) |=> INPUT_RANGE == $past(sel_s))
      else $error("hardware range not decoded");
   mode_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !full_release |=> $stable(hw_lat)) else $error("mode changed");
   burst_capture_a: assert property (@(posedge CLK) disable iff (!RST_N)
      full_release |=> burst_lat == $past(burst_s))
      else $error("burst strap not captured");
   burst_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !hw_lat |=> !BURST_ENABLE)
      else $error("burst outside hardware mode");
   shutdown_a: assert property (@(posedge CLK) disable iff (!RST_N)
      state == pscl_pkg::PSCL_LOW && !rst_pin_n && low_cnt >= shut_thr |=> SHUTDOWN)
      else $error("shutdown missed");
   shut_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      SHUTDOWN && !rst_pin_n |=> SHUTDOWN)
      else $error("shutdown left early");
   classify_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !(full_release && partial_release)) else $error("both reset kinds");
   short_ign_a: assert property (@(posedge CLK) disable iff (!RST_N)
      rst_pin_n && state == pscl_pkg::PSCL_LOW && low_cnt < partial_thr && low_cnt < full_thr
         |=> !FULL_RESET_PULSE && !PARTIAL_RESET_PULSE)
      else $error("short pulse classified");
   partial_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
      partial_release |=> $stable(ref_lat) && $stable(seq_lat) && $stable(hw_lat))
      else $error("partial reset recaptured straps");
   par_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !par_lat |=> PARALLEL_IFACE) else $error("parallel not selected");
   par_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !full_release |=> $stable(par_lat))
      else $error("interface strap changed");
   sync_delay_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(RST_N) && $past(RST_N, 2) |-> rst_pin_n == $past(RESET_PIN_N, 2))
      else $error("reset pin not synchronised");
   bvalid_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped");
   rvalid_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read data dropped");

   ////////////////////////////////////////////////////////////////////////////
   // covers for the main scenarios
   full_c: cover property (@(posedge CLK) disable iff (!RST_N) FULL_RESET_PULSE);
   partial_c: cover property (@(posedge CLK) disable iff (!RST_N) PARTIAL_RESET_PULSE);
   shut_c: cover property (@(posedge CLK) disable iff (!RST_N) SHUTDOWN);
   hw_c: cover property (@(posedge CLK) disable iff (!RST_N) HARDWARE_MODE && BURST_ENABLE);
   range10_c: cover property (@(posedge CLK) disable iff (!RST_N)
      HARDWARE_MODE && INPUT_RANGE == pscl_pkg::RANGE_10V);
endmodule : pscl_strap_latch

//--- sim/pscl_board_model.sv
// host board model that drives the strap and reset pins
module pscl_board_model (
   input wire logic CLK,
   output logic RESET_PIN_N,
   output logic REF_SOURCE_SELECT,
   output logic SEQUENCER_ENABLE_STRAP,
   output logic MODE_RANGE_SELECT_HI,
   output logic MODE_RANGE_SELECT_LO,
   output logic INTERFACE_SELECT_STRAP,
   output logic BURST_STRAP
);
   timeunit 1ns;
   timeprecision 1ps;
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      RESET_PIN_N = 1'b1;
      INTERFACE_SELECT_STRAP = 1'b0;
      BURST_STRAP = 1'b0;
      MODE_RANGE_SELECT_HI = 1'b0;
      MODE_RANGE_SELECT_LO = 1'b0;
      SEQUENCER_ENABLE_STRAP = 1'b0;
      REF_SOURCE_SELECT = 1'b1;
   end
   // s = {burst, hi, lo, seq, ref}; straps settle well before any release
   task automatic set_straps(input logic [4:0] s);
      logic sw;
      sw = (s[3:2] == 2'h0);
      BURST_STRAP <= s[4];
      MODE_RANGE_SELECT_HI <= s[3];
      MODE_RANGE_SELECT_LO <= s[2];
      SEQUENCER_ENABLE_STRAP <= s[1] & !sw;
      REF_SOURCE_SELECT <= s[0];
      INTERFACE_SELECT_STRAP <= 1'b0;
      repeat (4) @(posedge CLK);
   endtask : set_straps
   task automatic set_range(input logic [1:0] c);
      MODE_RANGE_SELECT_HI <= c[1];
      MODE_RANGE_SELECT_LO <= c[0];
      repeat (5) @(posedge CLK);
   endtask : set_range
   // high is only legal while no full reset release is pending
   task automatic set_iface(input logic v);
      INTERFACE_SELECT_STRAP <= v;
      repeat (4) @(posedge CLK);
   endtask : set_iface
   task automatic drive_reset(input logic v);
      RESET_PIN_N <= v;
   endtask : drive_reset
endmodule : pscl_board_model

//--- sim/test_pin_strap_config_latch.sv
// self-checking bench for the pin-strap configuration latch
module test_pin_strap_config_latch;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire logic pin_n, rsel, sstrap, shi, slo, ifs, bstrap;
   logic int_ref, seq_en, burst_en, hw_mode, par_if, shut, full_p, part_p;
   logic [1:0] range, bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] rdata;
   int n_errors = 0;
   int samples_checked = 0;
   int n_full = 0;
   int n_part = 0;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   pscl_board_model board_u (.CLK(clk), .RESET_PIN_N(pin_n), .REF_SOURCE_SELECT(rsel),
      .SEQUENCER_ENABLE_STRAP(sstrap), .MODE_RANGE_SELECT_HI(shi), .MODE_RANGE_SELECT_LO(slo),
      .INTERFACE_SELECT_STRAP(ifs), .BURST_STRAP(bstrap));
   // small thresholds keep the shutdown run short
   pscl_strap_latch #(.PARTIAL_CYCLES(2), .FULL_CYCLES(8), .SHUTDOWN_CYCLES(40)) dut_u (
      .CLK(clk), .RST_N(rst_n), .RESET_PIN_N(pin_n), .REF_SOURCE_SELECT(rsel),
      .SEQUENCER_ENABLE_STRAP(sstrap), .MODE_RANGE_SELECT_HI(shi), .MODE_RANGE_SELECT_LO(slo),
      .INTERFACE_SELECT_STRAP(ifs), .BURST_STRAP(bstrap), .INT_REF_ENABLE(int_ref),
      .SEQUENCER_ENABLE(seq_en), .BURST_ENABLE(burst_en), .HARDWARE_MODE(hw_mode),
      .INPUT_RANGE(range), .PARALLEL_IFACE(par_if), .SHUTDOWN(shut), .FULL_RESET_PULSE(full_p),
      .PARTIAL_RESET_PULSE(part_p), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   // pulses are one cycle wide, so sample them mid-cycle
   always @(negedge clk) begin
      if (full_p === 1'b1) n_full++;
      if (part_p === 1'b1) n_part++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // handshakes are judged at the rising edge, with the values the slave sampled there
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] r);
      logic aw, w, b;
      logic [1:0] rs;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      rs = 2'h0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
         @(posedge clk);
         if (!aw && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
         if (bvalid) begin
            b = 1'b1;
            rs = bresp;
            bready <= 1'b0;
         end
      end
      chk({30'h0, rs}, {30'h0, r});
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
      logic ar, rv;
      logic [31:0] rdv;
      logic [1:0] rs;
      ar = 1'b0;
      rv = 1'b0;
      rdv = 32'h0;
      rs = 2'h0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rv) begin
         @(posedge clk);
         if (!ar && arready) begin
            ar = 1'b1;
            arvalid <= 1'b0;
         end
         if (rvalid) begin
            rv = 1'b1;
            rdv = rdata;
            rs = rresp;
            rready <= 1'b0;
         end
      end
      chk(rdv, d);
      chk({30'h0, rs}, {30'h0, r});
      @(posedge clk);
   endtask : rd
   // same layout as the config register
   task automatic outs(input logic [6:0] e);
      chk({25'h0, par_if, range, hw_mode, burst_en, seq_en, int_ref}, {25'h0, e});
   endtask : outs
   task automatic pulse(input int n);
      board_u.drive_reset(1'b0);
      repeat (n) @(posedge clk);
      board_u.drive_reset(1'b1);
      repeat (8) @(posedge clk);
   endtask : pulse
   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge clk);
      n_errors++;
      final_report();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      outs(7'h41);
      rd(4'h0, 32'h41, 2'h0);
      wr(4'h8, 32'h0012_0300, 4'hf, 2'h0);
      rd(4'h8, 32'h0012_0300, 2'h0);
      wr(4'h0, 32'h1, 4'hf, 2'h2);
      rd(4'hc, 32'h0, 2'h2);
      $display("test registers done");
      board_u.set_straps(5'h16);
      pulse(12);
      chk(n_full, 1);
      outs(7'h5e);
      rd(4'h0, 32'h5e, 2'h0);
      $display("test hardware full reset done");
      board_u.set_range(2'h3);
      outs(7'h7e);
      board_u.set_range(2'h2);
      outs(7'h6e);
      board_u.set_range(2'h0);
      outs(7'h4e);
      $display("test live range done");
      board_u.set_straps(5'h09);
      pulse(5);
      chk(n_part, 1);
      chk(n_full, 1);
      outs(7'h6e);
      pulse(1);
      chk(n_part + n_full, 2);
      $display("test partial and short pulse done");
      // only byte 0 lands: override on, partial 3, full 18
      wr(4'h8, 32'hffff_ff01, 4'h1, 2'h0);
      rd(4'h8, 32'h0012_0301, 2'h0);
      board_u.set_iface(1'b1);
      pulse(12);
      chk(n_part, 2);
      outs(7'h6e);
      board_u.set_straps(5'h09);
      pulse(20);
      chk(n_full, 2);
      outs(7'h69);
      $display("test programmed thresholds done");
      board_u.set_straps(5'h03);
      board_u.drive_reset(1'b0);
      repeat (55) @(posedge clk);
      chk(shut, 1);
      rd(4'h4, 32'h0001_0035, 2'h0);
      board_u.drive_reset(1'b1);
      repeat (8) @(posedge clk);
      chk(shut, 0);
      chk(n_full, 3);
      outs(7'h41);
      $display("test shutdown done");
      final_report();
   end
endmodule : test_pin_strap_config_latch
